// ==== common/bsd_pkg.sv ====
// shared types and constants for the branch and system-control decoder
package bsd_pkg;
  localparam int          DATA_W       = 32;
  localparam int          REG_W        = 4;
  localparam int          DISP_W       = 8;
  // branch targets are relative to the instruction address plus four
  localparam logic [31:0] PC_AHEAD     = 32'h0000_0004;
  // extra cycles paid when fetch and data access share the memory path
  localparam logic [1:0]  CONTEND_WAIT = 2'h1;
  // displacement shift per operand size: x1, x2, x4
  localparam logic [1:0]  SH_BYTE      = 2'h0;
  localparam logic [1:0]  SH_WORD      = 2'h1;
  localparam logic [1:0]  SH_LONG      = 2'h2;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_OTHER,
    OP_LOAD,
    OP_STORE,
    OP_BRANCH_IF_FLAG_FALSE,
    OP_BRANCH_IF_FLAG_FALSE_DLY,
    OP_BRANCH_IF_FLAG_TRUE,
    OP_BRANCH_IF_FLAG_TRUE_DLY,
    OP_SUB_RETURN,
    OP_EXCEPTION_RETURN,
    OP_TLB_ENTRY_LOAD,
    OP_CACHE_PREFETCH,
    OP_SLEEP
  } bsd_op_type;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} bsd_size_type;

  // predecoded instruction from the fetch unit
  typedef struct packed {
    bsd_op_type          op;
    bsd_size_type        size;
    logic [DISP_W-1:0]   disp;
    logic [REG_W-1:0]    rn;
    logic [REG_W-1:0]    rm;
    logic                uses_rn;
    logic                uses_rm;
    logic [DATA_W-1:0]   pc;
  } bsd_ins_type;

  // instruction handed to the execution and memory units
  typedef struct packed {
    logic                valid;
    bsd_op_type          op;
    logic [REG_W-1:0]    rn;
    logic                reg_we;
    logic [DATA_W-1:0]   disp_scaled;
  } bsd_issue_type;

  typedef struct packed {
    logic                valid;
    logic [DATA_W-1:0]   target;
  } bsd_redirect_type;

  typedef struct packed {
    logic                we;
    logic [DATA_W-1:0]   high;
    logic [DATA_W-1:0]   low;
  } bsd_tlb_type;
endpackage

// ==== rtl/bsd_core.sv ====
// branch and system-control decode and issue sequencer
// What this block does
// (RL1) false-flag branches go only with flag clear, true-flag branches only with it set
// (RL2) subroutine return resumes at the saved return address
// (RL3) exception return ends handling and resumes the interrupted flow
// (RL4) tlb entry load writes page entry high and low into a tlb entry
// (RL5) cache prefetch requests a line and writes no general register
// (RL6) sleep moves the core from normal operation into power-down
// (RL7) listed cycle counts are minimums; waits may stretch execution
// (RL8) fetch and data access contention adds execution cycles
// (RL9) use of a just-loaded register stalls until the load data arrives
// (RL10) displacement scaled by one, two or four by operand size
// (RL11) delayed branches run the following slot instruction before redirecting
`timescale 1ns/1ps
module bsd_core
  import bsd_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // instruction from fetch
  input  wire logic              ins_valid,
  input  wire bsd_ins_type       ins,
  output logic                   ins_ready_r,
  // core state
  input  wire logic              t_flag,
  input  wire logic [DATA_W-1:0] ret_addr,
  input  wire logic [DATA_W-1:0] exc_ret_addr,
  input  wire logic [DATA_W-1:0] rn_value,
  input  wire logic [DATA_W-1:0] page_entry_high,
  input  wire logic [DATA_W-1:0] page_entry_low,
  // memory path status
  input  wire logic              fetch_busy,
  input  wire logic              load_done,
  // wake-up from the interrupt controller
  input  wire logic              wake_req,
  // issue to execution
  output bsd_issue_type          iss_r,
  output bsd_redirect_type       redirect_r,
  output logic                   exc_ret_r,
  output bsd_tlb_type            tlb_r,
  output logic                   pf_req_r,
  output logic [DATA_W-1:0]      pf_addr_r,
  output logic                   sleep_r
);
  typedef enum logic [1:0] {ST_RUN, ST_SLOT, ST_SLEEP} bsd_state_type;

  bsd_state_type     state_r;
  bsd_state_type     state_nxt;
  bsd_ins_type       cur_r;
  logic              cur_vld_r;
  logic              cur_vld_nxt;
  logic [DATA_W-1:0] slot_target_r;
  logic              take;
  logic              issue;
  logic              stall;
  logic              br_cond;
  logic              br_taken;
  logic              br_delayed;
  logic [DATA_W-1:0] br_target;
  logic [DATA_W-1:0] disp_scaled;

  bsd_disp_scale u_scale (
    .disp   (cur_r.disp),
    .size   (cur_r.size),
    .scaled (disp_scaled)
  );

  bsd_stall u_stall (
    .clk        (clk),
    .srst       (srst),
    .load_issue (issue && cur_r.op == OP_LOAD),
    .load_dest  (cur_r.rn),
    .load_done  (load_done),
    .cur_vld    (cur_vld_r),
    .cur        (cur_r),
    .issue      (issue),
    .fetch_busy (fetch_busy),
    .stall      (stall)
  );

  // handshake and issue qualifiers
  assign take  = ins_valid && ins_ready_r;
  assign issue = cur_vld_r && !stall && state_r != ST_SLEEP; // RL7

  // flag test and pc-relative target, displacement counted in words
  always_comb
  begin
    br_cond    = 1'b0;
    br_delayed = 1'b0;
    unique case (cur_r.op)
      OP_BRANCH_IF_FLAG_FALSE:     br_cond = !t_flag; // RL1
      OP_BRANCH_IF_FLAG_FALSE_DLY:
      begin
        br_cond    = !t_flag; // RL1
        br_delayed = 1'b1;
      end
      OP_BRANCH_IF_FLAG_TRUE:      br_cond = t_flag; // RL1
      OP_BRANCH_IF_FLAG_TRUE_DLY:
      begin
        br_cond    = t_flag; // RL1
        br_delayed = 1'b1;
      end
      default:                     br_cond = 1'b0;
    endcase
    // a branch sitting in a delay slot is illegal and is not taken
    br_taken  = issue && br_cond && state_r == ST_RUN;
    br_target = cur_r.pc + PC_AHEAD +
                {{(DATA_W-DISP_W-1){cur_r.disp[DISP_W-1]}}, cur_r.disp, 1'b0};
  end

  // sequencing state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
      begin
        if (br_taken && br_delayed)
          state_nxt = ST_SLOT; // RL11
        else if (issue && cur_r.op == OP_SLEEP)
          state_nxt = ST_SLEEP; // RL6
      end
      ST_SLOT:
      begin
        if (issue)
          state_nxt = ST_RUN; // RL11
      end
      ST_SLEEP:
      begin
        if (wake_req)
          state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // one-entry holding slot; ready is registered, so at most one
  // instruction every two cycles, which is the minimum listed count
  assign cur_vld_nxt = (cur_vld_r && !issue) || take;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur_vld_r   <= 1'b0;
      ins_ready_r <= 1'b0;
    end
    else
    begin
      cur_vld_r   <= cur_vld_nxt;
      ins_ready_r <= !cur_vld_nxt && state_nxt != ST_SLEEP; // RL7
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cur_r <= '0;
    else if (take)
      cur_r <= ins;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      slot_target_r <= ADDR_RESET;
    else if (br_taken && br_delayed)
      slot_target_r <= br_target; // RL11
  end

  // issue record; prefetch and stores leave the register file alone
  always_ff @(posedge clk)
  begin
    if (srst)
      iss_r <= '0;
    else
    begin
      iss_r.valid       <= issue;
      iss_r.op          <= cur_r.op;
      iss_r.rn          <= cur_r.rn;
      iss_r.reg_we      <= issue && cur_r.op inside {OP_LOAD, OP_OTHER}; // RL5
      iss_r.disp_scaled <= disp_scaled; // RL10
    end
  end

  // control transfer: immediate branches, returns, end of delay slot
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      redirect_r <= '0;
      exc_ret_r  <= 1'b0;
    end
    else
    begin
      redirect_r.valid <= 1'b0;
      exc_ret_r        <= 1'b0;
      if (state_r == ST_SLOT && issue)
      begin
        redirect_r.valid  <= 1'b1; // RL11
        redirect_r.target <= slot_target_r;
      end
      else if (br_taken && !br_delayed)
      begin
        redirect_r.valid  <= 1'b1; // RL1
        redirect_r.target <= br_target;
      end
      else if (issue && state_r == ST_RUN && cur_r.op == OP_SUB_RETURN)
      begin
        redirect_r.valid  <= 1'b1; // RL2
        redirect_r.target <= ret_addr;
      end
      else if (issue && state_r == ST_RUN && cur_r.op == OP_EXCEPTION_RETURN)
      begin
        redirect_r.valid  <= 1'b1; // RL3
        redirect_r.target <= exc_ret_addr;
        exc_ret_r         <= 1'b1;
      end
    end
  end

  // tlb entry write from the page entry registers
  always_ff @(posedge clk)
  begin
    if (srst)
      tlb_r <= '0;
    else
    begin
      tlb_r.we <= issue && cur_r.op == OP_TLB_ENTRY_LOAD; // RL4
      if (issue && cur_r.op == OP_TLB_ENTRY_LOAD)
      begin
        tlb_r.high <= page_entry_high; // RL4
        tlb_r.low  <= page_entry_low;
      end
    end
  end

  // prefetch request carries only an address, no register write back
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pf_req_r  <= 1'b0;
      pf_addr_r <= ADDR_RESET;
    end
    else
    begin
      pf_req_r <= issue && cur_r.op == OP_CACHE_PREFETCH; // RL5
      if (issue && cur_r.op == OP_CACHE_PREFETCH)
        pf_addr_r <= rn_value;
    end
  end

  // power-down level follows the sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
      sleep_r <= 1'b0;
    else
      sleep_r <= state_nxt == ST_SLEEP; // RL6
  end

  bf_taken_a: assert property (@(posedge clk) disable iff (srst) // RL1
    issue && state_r == ST_RUN && cur_r.op == OP_BRANCH_IF_FLAG_FALSE && !t_flag
    |=> redirect_r.valid && redirect_r.target == $past(br_target))
    else $error("false-flag branch not taken with flag clear");
  bt_hold_a: assert property (@(posedge clk) disable iff (srst) // RL1
    issue && state_r == ST_RUN && cur_r.op == OP_BRANCH_IF_FLAG_TRUE && !t_flag
    |=> !redirect_r.valid)
    else $error("true-flag branch taken with flag clear");
  sub_return_a: assert property (@(posedge clk) disable iff (srst) // RL2
    issue && state_r == ST_RUN && cur_r.op == OP_SUB_RETURN
    |=> redirect_r.valid && redirect_r.target == $past(ret_addr))
    else $error("return did not resume at saved address");
  exc_return_a: assert property (@(posedge clk) disable iff (srst) // RL3
    issue && state_r == ST_RUN && cur_r.op == OP_EXCEPTION_RETURN
    |=> exc_ret_r && redirect_r.target == $past(exc_ret_addr))
    else $error("exception return did not resume flow");
  tlb_write_a: assert property (@(posedge clk) disable iff (srst) // RL4
    issue && cur_r.op == OP_TLB_ENTRY_LOAD
    |=> tlb_r.we && tlb_r.high == $past(page_entry_high)
        && tlb_r.low == $past(page_entry_low))
    else $error("tlb entry not written from page entry registers");
  pf_no_wb_a: assert property (@(posedge clk) disable iff (srst) // RL5
    issue && cur_r.op == OP_CACHE_PREFETCH |=> pf_req_r && !iss_r.reg_we)
    else $error("prefetch missing or wrote a register");
  sleep_enter_a: assert property (@(posedge clk) disable iff (srst) // RL6
    issue && state_r == ST_RUN && cur_r.op == OP_SLEEP && !wake_req
    |=> sleep_r && !ins_ready_r)
    else $error("sleep did not enter power-down");
  min_cycles_a: assert property (@(posedge clk) disable iff (srst) // RL7
    take |=> !ins_ready_r)
    else $error("instruction accepted faster than minimum");
  stall_hold_a: assert property (@(posedge clk) disable iff (srst) // RL9
    cur_vld_r && stall |=> cur_vld_r && !iss_r.valid)
    else $error("stalled instruction issued");
  disp_long_a: assert property (@(posedge clk) disable iff (srst) // RL10
    issue && cur_r.size == SZ_LONG |=> iss_r.disp_scaled == {22'h0, $past(cur_r.disp), 2'h0})
    else $error("long displacement not scaled by four");
  slot_order_a: assert property (@(posedge clk) disable iff (srst) // RL11
    br_taken && br_delayed |=> !redirect_r.valid && state_r == ST_SLOT)
    else $error("delayed branch redirected before its slot");

  bf_taken_c: cover property (@(posedge clk) disable iff (srst)
    br_taken && !br_delayed);
  slot_run_c: cover property (@(posedge clk) disable iff (srst)
    state_r == ST_SLOT && issue);
  sleep_wake_c: cover property (@(posedge clk) disable iff (srst)
    state_r == ST_SLEEP && wake_req);
  load_stall_c: cover property (@(posedge clk) disable iff (srst)
    cur_vld_r && stall);
endmodule

// ==== rtl/bsd_disp_scale.sv ====
// displacement scaling by operand size
`timescale 1ns/1ps
module bsd_disp_scale
  import bsd_pkg::*;
(
  // encoded field and operand size
  input  wire logic [DISP_W-1:0] disp,
  input  wire bsd_size_type      size,
  // scaled, zero-extended displacement
  output logic [DATA_W-1:0]      scaled
);
  logic [1:0] sh;

  // byte x1, word x2, long x4
  always_comb
  begin
    unique case (size)
      SZ_BYTE: sh = SH_BYTE;
      SZ_WORD: sh = SH_WORD;
      SZ_LONG: sh = SH_LONG;
      default: sh = SH_BYTE; // encoding 3 is unused
    endcase
    scaled = {{(DATA_W-DISP_W){1'b0}}, disp} << sh; // RL10
  end
endmodule

// ==== rtl/bsd_stall.sv ====
// load-use and fetch-contention stall logic
`timescale 1ns/1ps
module bsd_stall
  import bsd_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // load tracking
  input  wire logic             load_issue,
  input  wire logic [REG_W-1:0] load_dest,
  input  wire logic             load_done,
  // waiting instruction
  input  wire logic             cur_vld,
  input  wire bsd_ins_type      cur,
  input  wire logic             issue,
  // memory path
  input  wire logic             fetch_busy,
  // result
  output logic                  stall
);
  logic             pend_r;
  logic [REG_W-1:0] pend_dest_r;
  logic [1:0]       wait_r;
  logic             use_hit;
  logic             cur_mem;
  logic             contend;

  // a new load wins over the completion of the previous one
  always_ff @(posedge clk)
  begin
    if (srst)
      pend_r <= 1'b0;
    else if (load_issue)
      pend_r <= 1'b1;
    else if (load_done)
      pend_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pend_dest_r <= '0;
    else if (load_issue)
      pend_dest_r <= load_dest;
  end

  // contention wait counter, cleared once the instruction leaves
  always_ff @(posedge clk)
  begin
    if (srst || issue)
      wait_r <= '0;
    else if (contend)
      wait_r <= wait_r + 2'h1;
  end

  assign use_hit = pend_r && !load_done &&
                   ((cur.uses_rn && cur.rn == pend_dest_r) ||
                    (cur.uses_rm && cur.rm == pend_dest_r)); // RL9
  assign cur_mem = cur.op inside {OP_LOAD, OP_STORE, OP_CACHE_PREFETCH};
  assign contend = cur_vld && cur_mem && fetch_busy && wait_r != CONTEND_WAIT; // RL8
  assign stall   = use_hit || contend;

  load_use_a: assert property (@(posedge clk) disable iff (srst) // RL9
    cur_vld && pend_r && !load_done && cur.uses_rn && cur.rn == pend_dest_r |-> stall)
    else $error("dependent instruction not held behind load");
  contend_a: assert property (@(posedge clk) disable iff (srst) // RL8
    cur_vld && cur_mem && fetch_busy && wait_r == 2'h0 |-> stall)
    else $error("no extra cycle on fetch contention");
endmodule

// ==== sim/bsd_fetch_model.sv ====
// fetch unit and load return model facing the decoder
`timescale 1ns/1ps
module bsd_fetch_model
  import bsd_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // instruction port
  input  wire logic          ins_ready_r,
  output logic               ins_valid,
  output bsd_ins_type        ins,
  // load return, latency set by the bench
  input  wire bsd_issue_type iss_r,
  input  wire logic [3:0]    load_lat,
  output logic               load_done
);
  logic taken;
  int   cnt;

  initial
  begin
    ins_valid = 1'b0;
    ins       = '0;
    load_done = 1'b0;
    taken     = 1'b0;
    cnt       = 0;
  end

  // offer one instruction and hold it until the edge that takes it
  task automatic offer(input bsd_ins_type i);
    @(negedge clk);
    ins_valid = 1'b1;
    ins       = i;
    while (ins_ready_r !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    taken = 1'b1;
  endtask

  // a released bus shows the inverse so stale fields are never read as live
  always @(negedge clk)
    if (taken)
    begin
      ins_valid = 1'b0;
      ins       = ~ins;
      taken     = 1'b0;
    end

  // load data returns load_lat cycles after the load issues; a newer load restarts it
  always @(negedge clk)
  begin
    load_done = 1'b0;
    if (srst)
      cnt = 0;
    else if (iss_r.valid === 1'b1 && iss_r.op == OP_LOAD)
      cnt = int'(load_lat);
    else if (cnt > 0)
    begin
      cnt = cnt - 1;
      load_done = (cnt == 0);
    end
  end
endmodule

// ==== sim/test_branch_sysctl_decode.sv ====
// self-checking bench for the branch and system-control decoder
`timescale 1ns/1ps
module test_branch_sysctl_decode
  import bsd_pkg::*;
;
  logic             clk = 1'b0;
  logic             srst;
  logic             ins_valid;
  bsd_ins_type      ins;
  logic             ins_ready_r;
  logic             t_flag;
  logic [31:0]      ret_addr;
  logic [31:0]      exc_ret_addr;
  logic [31:0]      rn_value;
  logic [31:0]      page_entry_high;
  logic [31:0]      page_entry_low;
  logic             fetch_busy;
  logic             load_done;
  logic             wake_req;
  logic [3:0]       load_lat;
  logic             ld_prev;
  bsd_issue_type    iss_r;
  bsd_redirect_type redirect_r;
  logic             exc_ret_r;
  bsd_tlb_type      tlb_r;
  logic             pf_req_r;
  logic [31:0]      pf_addr_r;
  logic             sleep_r;
  int               error_cnt = 0;
  int               samples_checked = 0;

  bsd_core u_bsd_core (.clk(clk), .srst(srst), .ins_valid(ins_valid), .ins(ins),
    .ins_ready_r(ins_ready_r), .t_flag(t_flag), .ret_addr(ret_addr),
    .exc_ret_addr(exc_ret_addr), .rn_value(rn_value), .page_entry_high(page_entry_high),
    .page_entry_low(page_entry_low), .fetch_busy(fetch_busy), .load_done(load_done),
    .wake_req(wake_req), .iss_r(iss_r), .redirect_r(redirect_r), .exc_ret_r(exc_ret_r),
    .tlb_r(tlb_r), .pf_req_r(pf_req_r), .pf_addr_r(pf_addr_r), .sleep_r(sleep_r));

  bsd_fetch_model u_bsd_fetch_model (.clk(clk), .srst(srst), .ins_ready_r(ins_ready_r),
    .ins_valid(ins_valid), .ins(ins), .iss_r(iss_r), .load_lat(load_lat),
    .load_done(load_done));

  // 125 MHz core clock
  always #4 clk = ~clk;

  // remembers whether load data arrived in the cycle just ended
  always @(posedge clk)
    ld_prev <= load_done;

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  function automatic bsd_ins_type mk(bsd_op_type op, bsd_size_type sz, logic [7:0] d,
                                     logic [3:0] r, logic u);
    mk = '{op, sz, d, r, 4'h0, u, 1'b0, 32'h0000_1000};
  endfunction

  // send one instruction; lat counts edges from the take edge, itself included,
  // to the edge that raises the issue pulse, so an unstalled instruction gives 2
  task automatic go(input bsd_ins_type i, output int lat);
    lat = 1;
    u_bsd_fetch_model.offer(i);
    do
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    while (iss_r.valid !== 1'b1 && lat < 40);
  endtask

  // every conditional form against both flag values, slot checked on delayed ones
  task automatic t_branch();
    bsd_op_type  ops [4] = '{OP_BRANCH_IF_FLAG_FALSE, OP_BRANCH_IF_FLAG_FALSE_DLY,
                             OP_BRANCH_IF_FLAG_TRUE, OP_BRANCH_IF_FLAG_TRUE_DLY};
    int          lat;
    logic        tk;
    logic        dly;
    logic [7:0]  d;
    logic [31:0] tg;
    for (int k = 0; k < 8; k++)
    begin
      dly = k[1];
      tk  = k[2] ? k[0] : !k[0];
      d   = k[0] ? 8'h10 : 8'hf0;
      tg  = 32'h0000_1004 + {{23{d[7]}}, d, 1'b0};
      @(negedge clk);
      t_flag = k[0];
      go(mk(ops[k >> 1], SZ_WORD, d, 4'h0, 1'b0), lat);
      chk_int("branch latency", 2, lat);
      chk_word("branch redirect", dly ? 1'b0 : tk, redirect_r.valid);
      if (dly)
      begin
        go(mk(OP_OTHER, SZ_WORD, 8'h00, 4'h1, 1'b0), lat);
        chk_word("slot op", OP_OTHER, iss_r.op);
        chk_word("slot redirect", tk, redirect_r.valid);
      end
      if (tk)
        chk_word("branch target", tg, redirect_r.target);
    end
  endtask

  // subroutine and exception returns
  task automatic t_return();
    int lat;
    @(negedge clk);
    ret_addr     = 32'h0000_2468;
    exc_ret_addr = 32'h0000_8ace;
    go(mk(OP_SUB_RETURN, SZ_LONG, 8'h00, 4'h0, 1'b0), lat);
    chk_word("ret redirect", 1'b1, redirect_r.valid);
    chk_word("ret target", 32'h0000_2468, redirect_r.target);
    chk_word("ret not exc", 1'b0, exc_ret_r);
    go(mk(OP_EXCEPTION_RETURN, SZ_LONG, 8'h00, 4'h0, 1'b0), lat);
    chk_word("exc redirect", 1'b1, redirect_r.valid);
    chk_word("exc target", 32'h0000_8ace, redirect_r.target);
    chk_word("exc flag", 1'b1, exc_ret_r);
  endtask

  // tlb load, prefetch, and memory-path contention
  task automatic t_sysctl();
    int lat;
    @(negedge clk);
    page_entry_high = 32'h1357_9bdf;
    page_entry_low  = 32'h0246_8ace;
    rn_value        = 32'h0000_3c00;
    go(mk(OP_TLB_ENTRY_LOAD, SZ_LONG, 8'h00, 4'h0, 1'b0), lat);
    chk_word("tlb we", 1'b1, tlb_r.we);
    chk_word("tlb high", 32'h1357_9bdf, tlb_r.high);
    chk_word("tlb low", 32'h0246_8ace, tlb_r.low);
    go(mk(OP_CACHE_PREFETCH, SZ_LONG, 8'h00, 4'h2, 1'b1), lat);
    chk_word("pf req", 1'b1, pf_req_r);
    chk_word("pf addr", 32'h0000_3c00, pf_addr_r);
    chk_word("pf reg write", 1'b0, iss_r.reg_we);
    chk_int("pf latency", 2, lat);
    @(negedge clk);
    fetch_busy = 1'b1;
    go(mk(OP_CACHE_PREFETCH, SZ_LONG, 8'h00, 4'h2, 1'b1), lat);
    chk_int("pf contended", 2 + int'(CONTEND_WAIT), lat);
    go(mk(OP_STORE, SZ_WORD, 8'h01, 4'h2, 1'b1), lat);
    chk_int("store contended", 2 + int'(CONTEND_WAIT), lat);
    chk_word("store reg write", 1'b0, iss_r.reg_we);
    @(negedge clk);
    fetch_busy = 1'b0;
  endtask

  // displacement scaling for each operand size
  task automatic t_scale();
    int lat;
    for (int s = 0; s < 3; s++)
    begin
      go(mk(OP_LOAD, bsd_size_type'(s), 8'hff, 4'h3, 1'b0), lat);
      chk_word("disp scaled", 32'h0000_00ff << s, iss_r.disp_scaled);
      chk_word("load reg write", 1'b1, iss_r.reg_we);
      chk_word("load dest", 32'h0000_0003, iss_r.rn);
    end
  endtask

  // dependent use waits for load data, with a prompt and a slow return
  task automatic t_loaduse();
    int lat;
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk);
      load_lat = k[0] ? 4'h6 : 4'h3;
      go(mk(OP_LOAD, SZ_LONG, 8'h00, 4'h5, 1'b0), lat);
      go(mk(OP_OTHER, SZ_LONG, 8'h00, 4'h5, 1'b1), lat);
      chk_int("use stalled", 1, int'(lat > 2));
      chk_word("use after data", 1'b1, ld_prev);
    end
    go(mk(OP_LOAD, SZ_LONG, 8'h00, 4'h5, 1'b0), lat);
    go(mk(OP_OTHER, SZ_LONG, 8'h00, 4'h6, 1'b1), lat);
    chk_int("other reg free", 2, lat);
  endtask

  // sleep holds off fetch until woken
  task automatic t_sleep();
    int lat;
    go(mk(OP_SLEEP, SZ_LONG, 8'h00, 4'h0, 1'b0), lat);
    repeat (4) @(negedge clk);
    chk_word("asleep", 1'b1, sleep_r);
    chk_word("ready asleep", 1'b0, ins_ready_r);
    wake_req = 1'b1;
    @(negedge clk);
    wake_req = 1'b0;
    for (int n = 0; n < 10 && sleep_r !== 1'b0; n++)
      @(negedge clk);
    chk_word("woken", 1'b0, sleep_r);
    go(mk(OP_OTHER, SZ_LONG, 8'h00, 4'h1, 1'b0), lat);
    chk_int("after wake", 2, lat);
  endtask

  initial
  begin
    srst = 1'b1;
    t_flag = 1'b0;
    ret_addr = '0;
    exc_ret_addr = '0;
    rn_value = '0;
    page_entry_high = '0;
    page_entry_low = '0;
    fetch_busy = 1'b0;
    wake_req = 1'b0;
    load_lat = 4'h4;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk_word("ready in reset", 1'b0, ins_ready_r);
    t_branch();
    t_return();
    t_sysctl();
    t_scale();
    t_loaduse();
    t_sleep();
    finish_test();
  end

  // the whole run needs well under 1000 cycles
  initial
  begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule
